// [logic/mfr_consts.vh]
// Constants for the motor fault response block: codes, widths and timing.
// Assumes a single 40 MHz core clock; times are turned into cycle counts in the module.
`ifndef MFR_CONSTS_VH
`define MFR_CONSTS_VH

// Clock
`define MFR_CLK_KHZ 40000
`define MFR_CLK_PERIOD_NS 25

// Deglitch times (least times, rounded up to cycles)
`define MFR_OC_DEG_NS 1000
`define MFR_BUCK_DEG_NS 2000
`define MFR_HWIL_DEG_UNIT_NS 1000

// Retry units and no-motor window, in milliseconds
`define MFR_OC_RETRY_UNIT_MS 5
`define MFR_LOCK_RETRY_TIME_UNIT_MS 100
`define MFR_NOMTR_MS 500

// Widths
`define MFR_SYNC_W 10
`define MFR_DG_W 16
`define MFR_TMR_W 32
`define MFR_SPD_W 16
`define MFR_CUR_W 12

// Synchroniser bit positions
`define MFR_SY_HWIL 6
`define MFR_SY_BUCK 7
`define MFR_SY_VMLOW 8
`define MFR_SY_VMHYS 9

// Overcurrent response codes
`define MFR_OCM_LATCH 2'h0
`define MFR_OCM_RETRY 2'h1
`define MFR_OCM_REPORT 2'h2
`define MFR_OCM_OFF 2'h3

// Lock response code fields
`define MFR_LKM_GRP_RETRY 2'h1
`define MFR_LKFS_HS 2'h2
`define MFR_LKFS_LS 2'h3

// Gate drive state codes
`define MFR_GATE_RUN 2'h0
`define MFR_GATE_OFF 2'h1
`define MFR_GATE_HS 2'h2
`define MFR_GATE_LS 2'h3

// Expected back-EMF is the product scaled down by this field
`define MFR_BEMF_MSB 31
`define MFR_BEMF_LSB 16

`endif

// [logic/mfr_fault_core.v]
// Fault response logic of a three-phase motor driver: overcurrent, buck overcurrent,
// current-limit lock, motor lock with three detectors, and supply floor fault.
// Assumes comparator inputs are asynchronous; estimator values and the clear command
// come from logic on mclk_i.
//
// Functional notes
// - Overcurrent retry mode: FETs off, fault pin low, driver/overcurrent/FET flags set.
// - Retry mode: after retry interval restore drive, release pin, clear driver fault.
// - Overcurrent and per-FET flags stay set until clear-fault command.
// - Buck switch current over limit past deglitch: buck Hi-Z and enter reset.
// - Current-limit lock event when comparator stays high past configured deglitch.
// - Lock codes 00xx latch, pull pin low, FET state from low two bits.
// - Latched lock resumes only when condition gone and clear-fault written.
// - Lock codes 01xx apply FET state, resume and clear flags after retry interval.
// - Lock code 1000 only reports; clears when condition gone and clear written.
// - Lock or motor mode 1xx1 takes no action at all on its event.
// - Motor codes 00xx latch FET state, pin low, flags until condition gone and clear.
// - Motor codes 01xx apply FET state, set flags, resume and clear after retry.
// - Motor code 1000 keeps driving, only reports until condition gone and clear.
// - Any individually enabled lock detector firing raises a motor lock event.
// - Speed detector fires when estimated speed exceeds its threshold.
// - Back-EMF detector fires when estimated-expected difference exceeds threshold.
// - No-motor detector fires when one phase stays below threshold 500 ms.
// - Supply floor response 0: fault latches, FETs Hi-Z until clear-fault.
// - Supply floor response 1: fault clears itself once supply above floor plus 0.5 V.
// - Overcurrent latched mode: FETs off, pin low, resume on condition gone and clear.
`timescale 1ns/1ps
`include "mfr_consts.vh"

module mfr_fault_core #(
    parameter OC_RETRY_UNIT_CYC = `MFR_OC_RETRY_UNIT_MS * `MFR_CLK_KHZ,
    parameter LOCK_RETRY_TIME_UNIT_CYC = `MFR_LOCK_RETRY_TIME_UNIT_MS * `MFR_CLK_KHZ,
    parameter NOMTR_CYC = `MFR_NOMTR_MS * `MFR_CLK_KHZ
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Asynchronous comparator levels
    input wire [5:0] oc_fet_i,
    input wire hw_current_limit_cmp_i,
    input wire buck_oc_i,
    input wire supply_below_floor_i,
    input wire supply_above_floor_hys_i,
    // Configuration
    input wire [1:0] overcurrent_response_sel_i,
    input wire [1:0] overcurrent_retry_time_i,
    input wire [3:0] hw_current_limit_response_sel_i,
    input wire [3:0] hw_current_limit_deglitch_i,
    input wire [3:0] rotor_lock_response_sel_i,
    input wire [1:0] lock_retry_time_i,
    input wire speed_lock_enable_i,
    input wire bemf_lock_enable_i,
    input wire no_motor_enable_i,
    input wire [15:0] speed_lock_threshold_i,
    input wire [15:0] backemf_mismatch_threshold_i,
    input wire [11:0] absent_motor_current_threshold_i,
    input wire [2:0] supply_floor_level_i,
    input wire supply_floor_response_i,
    // Estimator values and command
    input wire motor_running_i,
    input wire [15:0] speed_est_i,
    input wire [15:0] bemf_est_i,
    input wire [15:0] bemf_const_i,
    input wire [35:0] phase_current_i,
    input wire clear_fault_cmd_i,
    // Drive state and fault pin
    output reg [1:0] gate_state_o,
    output reg fault_out_n_o,
    output reg buck_hiz_o,
    output reg reset_req_o,
    // Status flags
    output wire driver_fault_o,
    output wire bridge_overcurrent_flag_o,
    output wire [5:0] fet_overcurrent_flag_o,
    output reg controller_fault_o,
    output wire hw_current_limit_lock_o,
    output wire rotor_lock_flag_o,
    output wire overspeed_lock_o,
    output wire backemf_mismatch_lock_o,
    output wire absent_motor_event_o,
    output reg supply_floor_fault_o
);

    localparam OC_DEG_CYC = (`MFR_OC_DEG_NS + `MFR_CLK_PERIOD_NS - 1) / `MFR_CLK_PERIOD_NS;
    localparam BUCK_DEG_CYC = (`MFR_BUCK_DEG_NS + `MFR_CLK_PERIOD_NS - 1) / `MFR_CLK_PERIOD_NS;
    localparam HWIL_UNIT_CYC = (`MFR_HWIL_DEG_UNIT_NS + `MFR_CLK_PERIOD_NS - 1) / `MFR_CLK_PERIOD_NS;

    reg [`MFR_SYNC_W-1:0] sy_a;
    reg [`MFR_SYNC_W-1:0] sy_b;
    wire [7:0] dg_evt;
    wire [`MFR_DG_W-1:0] dg_lim [0:7];
    wire [31:0] hwil_prod;
    wire [`MFR_TMR_W-1:0] oc_rlim;
    wire [`MFR_TMR_W-1:0] lk_rlim;

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sy_a <= {`MFR_SYNC_W{1'h0}};
            sy_b <= {`MFR_SYNC_W{1'h0}};
        end else begin
            sy_a <= {supply_above_floor_hys_i, supply_below_floor_i, buck_oc_i, hw_current_limit_cmp_i, oc_fet_i};
            sy_b <= sy_a;
        end
    end

    assign hwil_prod = ({28'h0, hw_current_limit_deglitch_i} + 32'h1) * HWIL_UNIT_CYC;
    assign oc_rlim = ({30'h0, overcurrent_retry_time_i} + 32'h1) * OC_RETRY_UNIT_CYC;
    assign lk_rlim = ({30'h0, lock_retry_time_i} + 32'h1) * LOCK_RETRY_TIME_UNIT_CYC;

    // Deglitch: six bridge FETs, current-limit comparator, buck switch
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_dg
            reg [`MFR_DG_W-1:0] cnt;
            assign dg_lim[i] = (i < 6) ? OC_DEG_CYC[`MFR_DG_W-1:0] :
                               (i == 6) ? hwil_prod[`MFR_DG_W-1:0] : BUCK_DEG_CYC[`MFR_DG_W-1:0];
            // Pulses once per excursion, so a held level is one event
            assign dg_evt[i] = sy_b[i] && (cnt == dg_lim[i] - 16'h1);
            always @(posedge mclk_i) begin
                if (!rst_n_i || !sy_b[i]) begin
                    cnt <= {`MFR_DG_W{1'h0}};
                end else if (cnt != dg_lim[i]) begin
                    cnt <= cnt + 16'h1;
                end
            end
        end
    endgenerate

    // Bridge overcurrent
    reg oc_act;
    reg oc_retry;
    reg [`MFR_TMR_W-1:0] oc_tmr;
    reg drv_flt;
    reg bridge_overcurrent_flag;
    reg [5:0] fet_oc;
    wire oc_any = |dg_evt[5:0];
    wire oc_cond = |sy_b[5:0];
    wire oc_on = overcurrent_response_sel_i != `MFR_OCM_OFF;
    wire oc_shut = (overcurrent_response_sel_i == `MFR_OCM_LATCH) ||
                   (overcurrent_response_sel_i == `MFR_OCM_RETRY);

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            oc_act <= 1'h0;
            oc_retry <= 1'h0;
            oc_tmr <= {`MFR_TMR_W{1'h0}};
            drv_flt <= 1'h0;
            bridge_overcurrent_flag <= 1'h0;
            fet_oc <= 6'h00;
        end else begin
            if (clear_fault_cmd_i) begin
                bridge_overcurrent_flag <= 1'h0;
                fet_oc <= 6'h00;
            end
            if (oc_act && oc_retry) begin
                oc_tmr <= oc_tmr + 32'h1;
                if (oc_tmr == oc_rlim - 32'h1) begin
                    oc_act <= 1'h0;
                    drv_flt <= 1'h0;
                end
            end else if (clear_fault_cmd_i && !oc_cond) begin
                oc_act <= 1'h0;
                drv_flt <= 1'h0;
            end
            // Later assignments win: a new event beats a clear in the same cycle
            if (oc_any && oc_on) begin
                bridge_overcurrent_flag <= 1'h1;
                fet_oc <= (clear_fault_cmd_i ? 6'h00 : fet_oc) | dg_evt[5:0];
                drv_flt <= 1'h1;
                if (oc_shut) begin
                    oc_act <= 1'h1;
                    oc_retry <= overcurrent_response_sel_i == `MFR_OCM_RETRY;
                    oc_tmr <= {`MFR_TMR_W{1'h0}};
                end
            end
        end
    end

    // Motor lock detectors
    wire [2:0] det_lvl;
    reg [2:0] det_prev;
    reg [2:0] cnd_flag;
    wire [31:0] bemf_prod = speed_est_i * bemf_const_i;
    wire [15:0] bemf_exp = bemf_prod[`MFR_BEMF_MSB:`MFR_BEMF_LSB];
    wire [15:0] bemf_diff = (bemf_est_i >= bemf_exp) ? bemf_est_i - bemf_exp : bemf_exp - bemf_est_i;
    wire [2:0] nm_hit;

    assign det_lvl[0] = speed_lock_enable_i && motor_running_i && (speed_est_i > speed_lock_threshold_i);
    assign det_lvl[1] = bemf_lock_enable_i && motor_running_i && (bemf_diff > backemf_mismatch_threshold_i);
    assign det_lvl[2] = |nm_hit;

    generate
        for (i = 0; i < 3; i = i + 1) begin : g_nm
            reg [`MFR_TMR_W-1:0] cnt;
            wire low = phase_current_i[i*`MFR_CUR_W +: `MFR_CUR_W] < absent_motor_current_threshold_i;
            assign nm_hit[i] = cnt == NOMTR_CYC;
            always @(posedge mclk_i) begin
                if (!rst_n_i || !(no_motor_enable_i && motor_running_i && low)) begin
                    cnt <= {`MFR_TMR_W{1'h0}};
                end else if (cnt != NOMTR_CYC) begin
                    cnt <= cnt + 32'h1;
                end
            end
        end
    endgenerate

    wire [2:0] det_evt = det_lvl & ~det_prev;
    wire ml_evt = |det_evt;
    wire ml_cond = |det_lvl;

    // Lock responses: index 0 current-limit lock, index 1 motor lock
    wire [1:0] lk_act;
    wire [1:0] lk_flag;
    wire [1:0] lk_rel;
    wire [3:0] lk_fs;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_lk
            reg act;
            reg flag;
            reg rty;
            reg [1:0] fs;
            reg [`MFR_TMR_W-1:0] tmr;
            wire [3:0] mode = (i == 1) ? rotor_lock_response_sel_i : hw_current_limit_response_sel_i;
            wire ev = (i == 1) ? ml_evt : dg_evt[6];
            wire cond = (i == 1) ? ml_cond : sy_b[`MFR_SY_HWIL];
            wire dis = mode[3] && mode[0];
            wire tmo = act && rty && (tmr == lk_rlim - 32'h1);
            assign lk_rel[i] = tmo || ((!act || !rty) && clear_fault_cmd_i && !cond);
            assign lk_act[i] = act;
            assign lk_flag[i] = flag;
            assign lk_fs[2*i +: 2] = fs;
            always @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    act <= 1'h0;
                    flag <= 1'h0;
                    rty <= 1'h0;
                    fs <= 2'h0;
                    tmr <= {`MFR_TMR_W{1'h0}};
                end else begin
                    if (act && rty) begin
                        tmr <= tmr + 32'h1;
                    end
                    if (lk_rel[i]) begin
                        act <= 1'h0;
                        flag <= 1'h0;
                    end
                    if (ev && !dis) begin
                        flag <= 1'h1;
                        if (!mode[3]) begin
                            act <= 1'h1;
                            rty <= mode[3:2] == `MFR_LKM_GRP_RETRY;
                            fs <= mode[1:0];
                            tmr <= {`MFR_TMR_W{1'h0}};
                        end
                    end
                end
            end
        end
    endgenerate

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            det_prev <= 3'h0;
            cnd_flag <= 3'h0;
        end else begin
            det_prev <= det_lvl;
            if (ml_evt && !(rotor_lock_response_sel_i[3] && rotor_lock_response_sel_i[0])) begin
                cnd_flag <= (lk_rel[1] ? 3'h0 : cnd_flag) | det_evt;
            end else if (lk_rel[1]) begin
                cnd_flag <= 3'h0;
            end
        end
    end

    // Supply floor and buck overcurrent
    wire sf_en = supply_floor_level_i != 3'h0;
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            supply_floor_fault_o <= 1'h0;
            buck_hiz_o <= 1'h0;
            reset_req_o <= 1'h0;
        end else begin
            if (supply_floor_response_i ? sy_b[`MFR_SY_VMHYS] : clear_fault_cmd_i) begin
                supply_floor_fault_o <= 1'h0;
            end
            if (sf_en && sy_b[`MFR_SY_VMLOW]) begin
                supply_floor_fault_o <= 1'h1;
            end
            // Held until the device reset that the request triggers
            if (dg_evt[7]) begin
                buck_hiz_o <= 1'h1;
                reset_req_o <= 1'h1;
            end
        end
    end

    // Gate state: full shutdowns first, then current-limit lock, then motor lock
    function [1:0] fs_map;
        input [1:0] fs;
        begin
            fs_map = (fs == `MFR_LKFS_HS) ? `MFR_GATE_HS : (fs == `MFR_LKFS_LS) ? `MFR_GATE_LS : `MFR_GATE_OFF;
        end
    endfunction

    reg [1:0] next_gate;
    always @* begin
        next_gate = `MFR_GATE_RUN;
        if (oc_act || supply_floor_fault_o || buck_hiz_o) begin
            next_gate = `MFR_GATE_OFF;
        end else if (lk_act[0]) begin
            next_gate = fs_map(lk_fs[1:0]);
        end else if (lk_act[1]) begin
            next_gate = fs_map(lk_fs[3:2]);
        end
    end

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            gate_state_o <= `MFR_GATE_RUN;
            fault_out_n_o <= 1'h1;
            controller_fault_o <= 1'h0;
        end else begin
            gate_state_o <= next_gate;
            fault_out_n_o <= !(oc_act || (|lk_act) || supply_floor_fault_o || buck_hiz_o);
            controller_fault_o <= (|lk_flag) || supply_floor_fault_o;
        end
    end

    assign driver_fault_o = drv_flt;
    assign bridge_overcurrent_flag_o = bridge_overcurrent_flag;
    assign fet_overcurrent_flag_o = fet_oc;
    assign hw_current_limit_lock_o = lk_flag[0];
    assign rotor_lock_flag_o = lk_flag[1];
    assign overspeed_lock_o = cnd_flag[0];
    assign backemf_mismatch_lock_o = cnd_flag[1];
    assign absent_motor_event_o = cnd_flag[2];

endmodule // mfr_fault_core

// [dv/mfr_fault_core_props.sv]
// Concurrent checks on the ports of the motor fault response core.
// Assumes one clock domain and the synchronous active-low reset of the core.
`timescale 1ns/1ps
module mfr_fault_core_props #(
    parameter LOCK_RETRY_TIME_UNIT_CYC = 30
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire [1:0] overcurrent_response_sel_i,
    input wire [3:0] hw_current_limit_response_sel_i,
    input wire [3:0] rotor_lock_response_sel_i,
    input wire supply_floor_response_i,
    input wire clear_fault_cmd_i,
    input wire [1:0] gate_state_o,
    input wire fault_out_n_o,
    input wire buck_hiz_o,
    input wire reset_req_o,
    input wire driver_fault_o,
    input wire bridge_overcurrent_flag_o,
    input wire controller_fault_o,
    input wire hw_current_limit_lock_o,
    input wire rotor_lock_flag_o,
    input wire supply_floor_fault_o
);
    // Longest lock retry code plus slack for the flag pipeline
    localparam int LK_SPAN = 4 * LOCK_RETRY_TIME_UNIT_CYC + 4;
    wire [3:0] hs = hw_current_limit_response_sel_i;
    wire [3:0] rs = rotor_lock_response_sel_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    oc_shut_a: assert property (
        $rose(driver_fault_o) && overcurrent_response_sel_i == 2'h1 |=> gate_state_o == 2'h1 && !fault_out_n_o)
        else $error("overcurrent did not shut the bridge");
    oc_retry_a: assert property (
        $fell(driver_fault_o) && overcurrent_response_sel_i == 2'h1 |=> gate_state_o == 2'h0 && fault_out_n_o)
        else $error("retry did not restore drive");
    ocp_hold_a: assert property (
        bridge_overcurrent_flag_o && !clear_fault_cmd_i |=> bridge_overcurrent_flag_o)
        else $error("overcurrent flag dropped without clear");
    hw_state_a: assert property (
        $rose(hw_current_limit_lock_o) && !hs[3] |=> gate_state_o == (hs[1] ? hs[1:0] : 2'h1))
        else $error("wrong gate state on current limit lock");
    hw_off_a: assert property (
        hs[3] && hs[0] |-> !$rose(hw_current_limit_lock_o))
        else $error("disabled current limit lock acted");
    rotor_off_a: assert property (
        rs[3] && rs[0] |-> !$rose(rotor_lock_flag_o))
        else $error("disabled motor lock acted");
    hw_report_a: assert property (
        $rose(hw_current_limit_lock_o) && hs == 4'h8 |=> (fault_out_n_o && gate_state_o == 2'h0) [*3])
        else $error("report mode disturbed drive");
    ctrl_late_a: assert property (
        controller_fault_o == $past(hw_current_limit_lock_o || rotor_lock_flag_o || supply_floor_fault_o))
        else $error("controller fault does not follow lock flags");
    lock_retry_a: assert property (
        $rose(rotor_lock_flag_o) && rs[3:2] == 2'h1 |=> rotor_lock_flag_o ##[1:LK_SPAN] !rotor_lock_flag_o)
        else $error("motor lock retry did not end");
    buck_stick_a: assert property (
        buck_hiz_o |=> buck_hiz_o && reset_req_o)
        else $error("buck fault not held");
    floor_hold_a: assert property (
        supply_floor_fault_o && !supply_floor_response_i && !clear_fault_cmd_i |=> supply_floor_fault_o)
        else $error("latched floor fault dropped");
    floor_off_a: assert property (
        $rose(supply_floor_fault_o) |=> gate_state_o == 2'h1)
        else $error("floor fault left bridge driven");
    cover property ($rose(driver_fault_o));
    cover property ($fell(rotor_lock_flag_o) && rs[3:2] == 2'h1);
    cover property ($rose(supply_floor_fault_o));
endmodule // mfr_fault_core_props

bind mfr_fault_core mfr_fault_core_props #(.LOCK_RETRY_TIME_UNIT_CYC(LOCK_RETRY_TIME_UNIT_CYC)) mfr_fault_core_props_i (.*);

// [dv/mfr_ctl_model.sv]
// External controller model: watches the fault pin and issues clear-fault pulses.
// Assumes the caller enters clear just after a rising clock edge.
`timescale 1ns/1ps
module mfr_ctl_model (
    // Clock and pin
    input wire mclk_i,
    input wire fault_out_n_i,
    // Command
    output logic clear_o
);
    logic prev = 1'b1;
    integer pin_drops = 0;
    initial clear_o = 1'b0;
    // Counts falling edges of the fault pin seen by the controller
    always @(posedge mclk_i) begin
        prev <= fault_out_n_i;
        if (prev && !fault_out_n_i) begin
            pin_drops <= pin_drops + 1;
        end
    end
    // One-cycle pulse on the clear-fault command
    task clear;
        clear_o = 1'b1;
        @(posedge mclk_i);
        #1 clear_o = 1'b0;
    endtask
endmodule // mfr_ctl_model

// [dv/mfr_fault_core_tb.sv]
// Self-checking bench for the motor fault response core.
// Assumes shortened retry and no-motor counts set by parameters below.
`timescale 1ns/1ps
module mfr_fault_core_tb;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, hw_current_limit_cmp_i = 1'b0, buck_oc_i = 1'b0, kind_r = 1'b0;
    logic supply_below_floor_i = 1'b0, supply_above_floor_hys_i = 1'b0, supply_floor_response_i = 1'b0;
    logic speed_lock_enable_i = 1'b1, bemf_lock_enable_i = 1'b0, no_motor_enable_i = 1'b0, motor_running_i = 1'b1;
    logic [5:0] oc_fet_i = 6'h00;
    logic [1:0] overcurrent_response_sel_i = 2'h1, overcurrent_retry_time_i = 2'h1, lock_retry_time_i = 2'h1;
    logic [3:0] hw_current_limit_response_sel_i = 4'h9, hw_current_limit_deglitch_i = 4'h0;
    logic [3:0] rotor_lock_response_sel_i = 4'h9;
    logic [15:0] speed_lock_threshold_i = 16'h0800, backemf_mismatch_threshold_i = 16'h0800;
    logic [15:0] speed_est_i = 16'h0100, bemf_est_i = 16'h0000, bemf_const_i = 16'h0000;
    logic [11:0] absent_motor_current_threshold_i = 12'h100;
    logic [35:0] phase_current_i = {3{12'h400}};
    logic [2:0] supply_floor_level_i = 3'h1;
    wire clear_fault_cmd_i, fault_out_n_o, buck_hiz_o, reset_req_o, driver_fault_o, bridge_overcurrent_flag_o;
    wire controller_fault_o, hw_current_limit_lock_o, rotor_lock_flag_o, overspeed_lock_o;
    wire backemf_mismatch_lock_o, absent_motor_event_o, supply_floor_fault_o;
    wire [1:0] gate_state_o;
    wire [5:0] fet_overcurrent_flag_o;
    wire lk_flag = kind_r ? rotor_lock_flag_o : hw_current_limit_lock_o;
    integer fails = 0, samples_checked = 0, i;
    logic [3:0] codes [8] = '{4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};

    mfr_fault_core #(.OC_RETRY_UNIT_CYC(20), .LOCK_RETRY_TIME_UNIT_CYC(30), .NOMTR_CYC(50)) mfr_fault_core_i (.*);
    mfr_ctl_model mfr_ctl_model_i (.mclk_i(mclk_i), .fault_out_n_i(fault_out_n_o), .clear_o(clear_fault_cmd_i));

    always #12.5 mclk_i = ~mclk_i;

    task tick(input integer n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task chk(input [63:0] seen, input [63:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task clr;
        mfr_ctl_model_i.clear();
        tick(3);
    endtask
    task summarize;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // kind 0 drives the current-limit comparator, kind 1 the speed detector
    task lock_case(input logic kind, input [3:0] c);
        integer d0;
        logic [1:0] eg;
        logic fl;
        d0 = mfr_ctl_model_i.pin_drops;
        eg = c[3] ? 2'h0 : (c[1] ? c[1:0] : 2'h1);
        fl = !(c[3] & c[0]);
        kind_r = kind;
        if (kind) begin
            rotor_lock_response_sel_i = c;
            speed_est_i = 16'h0900;
            tick(10);
        end else begin
            hw_current_limit_response_sel_i = c;
            hw_current_limit_cmp_i = 1'b1;
            tick(50);
        end
        chk(gate_state_o, eg);
        chk(fault_out_n_o, c[3]);
        chk(lk_flag, fl);
        chk(kind ? overspeed_lock_o : controller_fault_o, fl);
        speed_est_i = 16'h0100;
        hw_current_limit_cmp_i = 1'b0;
        if (c[3:2] == 2'h1) begin
            tick(40);
            chk(lk_flag, 1'b1);
            tick(30);
        end else begin
            tick(5);
            chk(lk_flag, fl);
            clr();
        end
        chk(lk_flag, 1'b0);
        chk(gate_state_o, 2'h0);
        chk(mfr_ctl_model_i.pin_drops - d0, !c[3]);
        hw_current_limit_response_sel_i = 4'h9;
        rotor_lock_response_sel_i = 4'h9;
        tick(1);
    endtask

    initial begin
        #(25 * 20000);
        fails = fails + 1;
        summarize();
    end

    initial begin
        tick(5);
        rst_n_i = 1'b1;
        tick(2);
        chk({gate_state_o, fault_out_n_o, bridge_overcurrent_flag_o}, 4'h2);
        oc_fet_i = 6'h04;
        tick(46);
        chk({gate_state_o, fault_out_n_o, driver_fault_o, bridge_overcurrent_flag_o}, 5'h0b);
        chk(fet_overcurrent_flag_o, 6'h04);
        oc_fet_i = 6'h00;
        tick(30);
        chk({gate_state_o, fault_out_n_o, driver_fault_o}, 4'h5);
        tick(10);
        chk({gate_state_o, fault_out_n_o, driver_fault_o}, 4'h2);
        chk({bridge_overcurrent_flag_o, fet_overcurrent_flag_o}, 7'h44);
        clr();
        chk({bridge_overcurrent_flag_o, fet_overcurrent_flag_o}, 7'h00);
        overcurrent_response_sel_i = 2'h0;
        for (i = 0; i < 2; i++) begin
            oc_fet_i = 6'h20;
            tick(35);
            oc_fet_i = 6'h00;
            tick(2);
        end
        chk(driver_fault_o, 1'b0);
        oc_fet_i = 6'h20;
        tick(46);
        oc_fet_i = 6'h00;
        tick(30);
        chk({gate_state_o, fault_out_n_o}, 3'h2);
        clr();
        chk({gate_state_o, fault_out_n_o}, 3'h1);
        for (i = 0; i < 16; i++) lock_case(i[3], codes[i[2:0]]);
        // Deglitch code 1 doubles the window; code 0 would have fired already
        hw_current_limit_deglitch_i = 4'h1;
        hw_current_limit_response_sel_i = 4'h8;
        hw_current_limit_cmp_i = 1'b1;
        tick(60);
        chk(hw_current_limit_lock_o, 1'b0);
        tick(30);
        chk(hw_current_limit_lock_o, 1'b1);
        hw_current_limit_cmp_i = 1'b0;
        tick(5);
        clr();
        chk(hw_current_limit_lock_o, 1'b0);
        hw_current_limit_response_sel_i = 4'h9;
        speed_lock_enable_i = 1'b0;
        bemf_lock_enable_i = 1'b1;
        rotor_lock_response_sel_i = 4'h8;
        speed_est_i = 16'h0900;
        // Expected back-EMF is 0x0480 here, so only a difference above 0x0800 trips
        bemf_const_i = 16'h8000;
        bemf_est_i = 16'h0c80;
        tick(5);
        chk(rotor_lock_flag_o, 1'b0);
        bemf_est_i = 16'h0c81;
        tick(5);
        chk({rotor_lock_flag_o, backemf_mismatch_lock_o}, 2'h3);
        bemf_est_i = 16'h0000;
        bemf_lock_enable_i = 1'b0;
        no_motor_enable_i = 1'b1;
        phase_current_i[23:12] = 12'h0ff;
        tick(3);
        clr();
        tick(34);
        chk(absent_motor_event_o, 1'b0);
        tick(15);
        chk(absent_motor_event_o, 1'b1);
        phase_current_i[23:12] = 12'h400;
        no_motor_enable_i = 1'b0;
        tick(3);
        clr();
        rotor_lock_response_sel_i = 4'h9;
        for (i = 0; i < 3; i++) begin
            supply_floor_level_i = (i == 2) ? 3'h0 : 3'h1;
            supply_floor_response_i = i[0];
            supply_below_floor_i = 1'b1;
            tick(5);
            chk({supply_floor_fault_o, gate_state_o}, (i == 2) ? 3'h0 : 3'h5);
            supply_below_floor_i = 1'b0;
            supply_above_floor_hys_i = i[0];
            tick(5);
            chk(supply_floor_fault_o, i == 0);
            clr();
            chk({supply_floor_fault_o, gate_state_o}, 3'h0);
            supply_above_floor_hys_i = 1'b0;
        end
        buck_oc_i = 1'b1;
        tick(70);
        buck_oc_i = 1'b0;
        tick(10);
        chk(buck_hiz_o, 1'b0);
        buck_oc_i = 1'b1;
        tick(90);
        chk({buck_hiz_o, reset_req_o}, 2'h3);
        buck_oc_i = 1'b0;
        rst_n_i = 1'b0;
        tick(5);
        rst_n_i = 1'b1;
        tick(2);
        chk({buck_hiz_o, reset_req_o, fault_out_n_o}, 3'h1);
        summarize();
    end
endmodule // mfr_fault_core_tb
